// ==== mrs_pkg.sv ====
package mrs_pkg;
   // Target address width and data word widths
   localparam int MRS_ADDR_W = 7;
   localparam int MRS_RES_W = 12;
   localparam logic [3:0] MRS_BITS_PER_BYTE = 4'h8;
   // Data bytes returned per read mode
   localparam logic [1:0] MRS_BYTES_STATUS = 2'h1;
   localparam logic [1:0] MRS_BYTES_SINGLE = 2'h2;
   localparam logic [1:0] MRS_BYTES_BOTH = 2'h3;
   // Status byte field positions
   localparam int MRS_ST_ADC_LIMIT_COMPARE_FLAG = 0;
   localparam int MRS_ST_ADC_ALERT = 1;
   localparam int MRS_ST_SWITCH_OFF_OVERCURRENT_FLAG = 2;
   localparam int MRS_ST_SWITCH_FAILURE_STICKY_FLAG = 3;
   localparam int MRS_ST_OFF = 4;
   localparam int MRS_ST_OFF_ALERT = 5;
   // Reset values
   localparam logic [7:0] MRS_STATUS_RST = 8'h00;
   localparam logic [3:0] MRS_HIST_RST = 4'h0;
   localparam logic [11:0] MRS_RESULT_RST = 12'h000;
   // Conversions that must all exceed the threshold
   localparam int MRS_OC_RUN = 3;
   // Read engine states
   typedef enum logic [4:0] {
      MRS_IDLE = 5'h01,
      MRS_ADDR = 5'h02,
      MRS_AACK = 5'h04,
      MRS_SEND = 5'h08,
      MRS_MACK = 5'h10
   } mrs_state_t;
endpackage : mrs_pkg

// ==== mrs_bus_if.sv ====
`timescale 1ns/10ps
interface mrs_bus_if;
   logic scl_rise; // Clock line rose
   logic scl_fall; // Clock line fell
   logic start_det; // Start or repeated start seen
   logic stop_det; // Stop seen
   logic sda_level; // Delayed data line level
   modport sense (output scl_rise, scl_fall, start_det, stop_det, sda_level);
   modport core (input scl_rise, scl_fall, start_det, stop_det, sda_level);
endinterface : mrs_bus_if

// ==== mrs_pin_sense.sv ====
`timescale 1ns/10ps
module mrs_pin_sense import mrs_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   mrs_bus_if.sense bus
);
   logic [1:0] scl_d; // Two samples of the clock line
   logic [1:0] sda_d; // Two samples of the data line
   logic [1:0] next_scl_d;
   logic [1:0] next_sda_d;

   // Shift in the line samples
   always_comb begin
      next_scl_d = {scl_d[0], scl_in};
      next_sda_d = {sda_d[0], sda_in};
   end

   // Lines idle high after reset
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_d <= 2'h3;
         sda_d <= 2'h3;
      end else begin
         scl_d <= next_scl_d;
         sda_d <= next_sda_d;
      end
   end

   // Edge and bus condition decode
   assign bus.scl_rise = scl_d[0] & ~scl_d[1];
   assign bus.scl_fall = ~scl_d[0] & scl_d[1];
   assign bus.start_det = scl_d[0] & scl_d[1] & sda_d[1] & ~sda_d[0];
   assign bus.stop_det = scl_d[0] & scl_d[1] & ~sda_d[1] & sda_d[0];
   assign bus.sda_level = sda_d[0];
endmodule : mrs_pin_sense

// ==== mrs_alert_flags.sv ====
`timescale 1ns/10ps
module mrs_alert_flags import mrs_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic result_valid_in,
   input wire logic [7:0] current_msb_in,
   input wire logic [7:0] current_alert_threshold_in,
   input wire logic en_single_oc_in,
   input wire logic en_run_oc_in,
   input wire logic switch_failure_alert_enable_in,
   input wire logic en_off_alert_in,
   input wire logic switch_off_overcurrent_flag_in,
   input wire logic switch_fail_event_in,
   input wire logic enable_pin_in,
   input wire logic software_force_disable_bit_in,
   input wire logic clear_write_in,
   output logic [7:0] status_out,
   output logic clear_pending_out
);
   logic [3:0] hist; // Compare results of recent conversions, newest in bit 0
   logic adc_sticky; // Trip raised the alert
   logic hs_sticky; // Switch failure seen
   logic off_sticky; // Off alert seen
   logic off_prev; // Off state one cycle ago
   logic clear_pend; // Clear bit as software sees it
   logic [3:0] next_hist;
   logic next_adc_sticky;
   logic next_hs_sticky;
   logic next_off_sticky;
   logic next_clear_pend;
   logic over_now; // This conversion exceeds the threshold
   logic off_now; // Switch held off by pin or software
   logic adc_trip; // Trip event this cycle

   assign over_now = current_msb_in > current_alert_threshold_in;
   assign off_now = ~enable_pin_in | software_force_disable_bit_in; // R10

   // Compute history and sticky flags; a set wins over a clear
   always_comb begin
      next_hist = hist;
      adc_trip = 1'b0;
      if (result_valid_in) begin
         next_hist = {hist[2:0], over_now};
         adc_trip = over_now & (en_single_oc_in | (en_run_oc_in & (&hist[2:0])));
      end
      next_adc_sticky = (adc_sticky & ~clear_pend) | adc_trip; // R7 R12
      next_hs_sticky = (hs_sticky & ~clear_pend) | (switch_fail_event_in & switch_failure_alert_enable_in); // R9 R12
      next_off_sticky = (off_sticky & ~clear_pend) | (en_off_alert_in & off_now & ~off_prev); // R11 R12
      next_clear_pend = clear_write_in; // R14
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         hist <= MRS_HIST_RST;
         adc_sticky <= 1'b0;
         hs_sticky <= 1'b0;
         off_sticky <= 1'b0;
         off_prev <= 1'b0;
         clear_pend <= 1'b0;
      end else begin
         hist <= next_hist;
         adc_sticky <= next_adc_sticky;
         hs_sticky <= next_hs_sticky;
         off_sticky <= next_off_sticky;
         off_prev <= off_now;
         clear_pend <= next_clear_pend;
      end
   end

   // Status byte assembly, upper bits zero
   always_comb begin
      status_out = MRS_STATUS_RST;
      status_out[MRS_ST_ADC_LIMIT_COMPARE_FLAG] = &hist[MRS_OC_RUN-1:0]; // R6
      status_out[MRS_ST_ADC_ALERT] = adc_sticky; // R7
      status_out[MRS_ST_SWITCH_OFF_OVERCURRENT_FLAG] = switch_off_overcurrent_flag_in; // R8
      status_out[MRS_ST_SWITCH_FAILURE_STICKY_FLAG] = hs_sticky; // R9
      status_out[MRS_ST_OFF] = off_now; // R10
      status_out[MRS_ST_OFF_ALERT] = off_sticky; // R11
   end
   assign clear_pending_out = clear_pend;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   a_adc_run_flag: assert property (result_valid_in && over_now && (&hist[1:0]) |=> status_out[0]) // R6
      else $error("adc compare flag missed three over results");
   a_sticky_hold: assert property (status_out[1] && !clear_pend |=> status_out[1]) // R7
      else $error("adc alert dropped without clear");
   a_off_status: assert property (software_force_disable_bit_in |-> status_out[4]) // R10
      else $error("off status low under force disable");
   a_clear_self: assert property (clear_pend && !clear_write_in |=> !clear_pend) // R14
      else $error("clear bit did not self clear");
   a_clear_all: assert property (clear_pend && !switch_fail_event_in |=> !status_out[3]) // R12
      else $error("switch failure flag survived clear");
endmodule : mrs_alert_flags

// ==== mrs_readback.sv ====
`timescale 1ns/10ps
// Function
// R1: Current mode: I[11:4], then I[3:0] and zeros
// R2: Ack own address with read bit first
// R3: Master acks two bytes, nacks third, stops
// R4: Single-channel modes send exactly two bytes
// R5: Status mode sends one status byte
// R6: Bit 0: last three conversions exceeded threshold
// R7: Bit 1: sticky ADC trip alert
// R8: Bit 2: switch off from analog overcurrent
// R9: Bit 3: sticky switch failure
// R10: Bit 4: enable pin low or forced off
// R11: Bit 5: sticky off alert
// R12: Only clear write clears sticky bits
// R13: Status-read bit selects status byte
// R14: Clear bit self-clears; flags may re-set
// R15: Combined mode: V msb, I msb, nibbles
// R16: Read bytes come from one captured set
module mrs_readback import mrs_pkg::*; (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic scl_in, // Bus clock, sampled
   input wire logic sda_in, // Bus data level
   output logic sda_out, // Data driven value, always low
   output logic sda_oe_n_out, // Low while pulling data low
   input wire logic [6:0] device_address_in, // Own target address
   input wire logic status_read_in, // Command status-read bit
   input wire logic convert_voltage_in, // Voltage channel selected
   input wire logic convert_current_in, // Current channel selected
   input wire logic result_valid_in, // Conversion set completed
   input wire logic [11:0] voltage_result_in,
   input wire logic [11:0] current_result_in,
   input wire logic [7:0] current_alert_threshold_in,
   input wire logic en_single_oc_in,
   input wire logic en_run_oc_in,
   input wire logic switch_failure_alert_enable_in,
   input wire logic en_off_alert_in,
   input wire logic switch_off_overcurrent_flag_in, // Live analog overcurrent off
   input wire logic switch_fail_event_in, // Switch failure pulse
   input wire logic enable_pin_in, // Hot-swap enable pin level
   input wire logic software_force_disable_bit_in,
   input wire logic clear_write_in, // Clear bit written high
   output logic clear_bit_out, // Clear bit readback
   output logic [7:0] alert_status_byte_out, // Live status byte
   output logic busy_out // Read transfer in progress
);
   mrs_bus_if bus (); // Edge events from the pins

   // Registered state of the read engine
   mrs_state_t state; // Read engine state
   logic [7:0] shreg; // Address shift register
   logic [3:0] cnt; // Bit counter
   logic drive; // Pull data low
   logic [23:0] obuf; // Outgoing bytes, MSB first
   logic [1:0] left; // Bytes still to finish
   logic mack; // Master acked last byte
   logic [11:0] v_hold; // Last completed voltage
   logic [11:0] i_hold; // Last completed current

   // Next values of the engine registers
   mrs_state_t next_state;
   logic [7:0] next_shreg;
   logic [3:0] next_cnt;
   logic next_drive;
   logic [23:0] next_obuf;
   logic [1:0] next_left;
   logic next_mack;
   logic [11:0] next_v_hold;
   logic [11:0] next_i_hold;

   // Mode decode and address match
   logic [23:0] load_bytes; // Bytes for the selected mode
   logic [1:0] load_count; // Byte count for the mode
   logic addr_hit; // Own address with read bit
   logic [7:0] status_byte; // Status from flag logic

   // Pin edge and condition detection
   mrs_pin_sense u_sense (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .bus(bus)
   );

   // Status flags
   mrs_alert_flags u_flags (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .result_valid_in(result_valid_in),
      .current_msb_in(current_result_in[11:4]),
      .current_alert_threshold_in(current_alert_threshold_in),
      .en_single_oc_in(en_single_oc_in),
      .en_run_oc_in(en_run_oc_in),
      .switch_failure_alert_enable_in(switch_failure_alert_enable_in),
      .en_off_alert_in(en_off_alert_in),
      .switch_off_overcurrent_flag_in(switch_off_overcurrent_flag_in),
      .switch_fail_event_in(switch_fail_event_in),
      .enable_pin_in(enable_pin_in),
      .software_force_disable_bit_in(software_force_disable_bit_in),
      .clear_write_in(clear_write_in),
      .status_out(status_byte),
      .clear_pending_out(clear_bit_out)
   );

   // Pick the byte layout for the selected read mode
   always_comb begin
      if (status_read_in) begin
         load_bytes = {status_byte, 16'h0000}; // R5 R13
         load_count = MRS_BYTES_STATUS;
      end else if (convert_voltage_in && convert_current_in) begin
         load_bytes = {v_hold[11:4], i_hold[11:4], v_hold[3:0], i_hold[3:0]}; // R15
         load_count = MRS_BYTES_BOTH;
      end else if (convert_voltage_in) begin
         load_bytes = {v_hold[11:4], v_hold[3:0], 4'h0, 8'h00}; // R4
         load_count = MRS_BYTES_SINGLE;
      end else begin
         load_bytes = {i_hold[11:4], i_hold[3:0], 4'h0, 8'h00}; // R1 R4
         load_count = MRS_BYTES_SINGLE;
      end
   end

   // Own address with the read direction bit set
   assign addr_hit = (shreg[7:1] == device_address_in) && shreg[0]; // R2

   // Next-state logic of the read engine
   always_comb begin
      next_state = state;
      next_shreg = shreg;
      next_cnt = cnt;
      next_drive = drive;
      next_obuf = obuf;
      next_left = left;
      next_mack = mack;
      next_v_hold = v_hold;
      next_i_hold = i_hold;
      // Results only change as a complete set
      if (result_valid_in) begin
         next_v_hold = voltage_result_in; // R16
         next_i_hold = current_result_in; // R16
      end
      if (bus.start_det) begin
         // Start aborts anything and begins address capture
         next_state = MRS_ADDR;
         next_cnt = 4'h0;
         next_drive = 1'b0;
      end else if (bus.stop_det) begin
         // Stop releases the bus
         next_state = MRS_IDLE;
         next_drive = 1'b0;
      end else begin
         unique case (state)
            MRS_IDLE: begin
               // Wait for a start
               next_drive = 1'b0;
            end
            MRS_ADDR: begin
               // Sample address bits on rising clock
               if (bus.scl_rise) begin
                  next_shreg = {shreg[6:0], bus.sda_level};
                  next_cnt = cnt + 4'h1;
               end
               if (bus.scl_fall && cnt == MRS_BITS_PER_BYTE) begin
                  if (addr_hit) begin
                     next_state = MRS_AACK;
                     next_drive = 1'b1; // R2
                     next_obuf = load_bytes; // R16
                     next_left = load_count; // R4 R5
                  end else begin
                     next_state = MRS_IDLE;
                  end
               end
            end
            MRS_AACK: begin
               // Ack bit ends; put out first data bit
               if (bus.scl_fall) begin
                  next_state = MRS_SEND;
                  next_cnt = 4'h0;
                  next_drive = ~obuf[23];
               end
            end
            MRS_SEND: begin
               // Shift data out on falling clock
               if (bus.scl_rise) begin
                  next_cnt = cnt + 4'h1;
               end
               if (bus.scl_fall) begin
                  next_obuf = {obuf[22:0], 1'b0};
                  if (cnt == MRS_BITS_PER_BYTE) begin
                     // Byte done: release for the master's answer
                     next_state = MRS_MACK;
                     next_drive = 1'b0;
                     next_left = left - 2'h1;
                  end else begin
                     next_drive = ~obuf[22];
                  end
               end
            end
            MRS_MACK: begin
               // Master answers; ack continues only while bytes remain
               if (bus.scl_rise) begin
                  next_mack = ~bus.sda_level;
               end
               if (bus.scl_fall) begin
                  if (mack && left != 2'h0) begin
                     next_state = MRS_SEND; // R3
                     next_cnt = 4'h0;
                     next_drive = ~obuf[23];
                  end else begin
                     // Last byte or not acked: let go of the bus
                     next_state = MRS_IDLE; // R3 R4
                     next_drive = 1'b0;
                  end
               end
            end
            default: begin
               // Illegal code: return to idle and free the bus
               next_state = MRS_IDLE;
               next_drive = 1'b0;
            end
         endcase
      end
   end

   // Register the read engine
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         // Bus released, no result captured yet
         state <= MRS_IDLE;
         shreg <= 8'h00;
         cnt <= 4'h0;
         drive <= 1'b0;
         obuf <= 24'h000000;
         left <= 2'h0;
         mack <= 1'b0;
         v_hold <= MRS_RESULT_RST;
         i_hold <= MRS_RESULT_RST;
      end else begin
         state <= next_state;
         shreg <= next_shreg;
         cnt <= next_cnt;
         drive <= next_drive;
         obuf <= next_obuf;
         left <= next_left;
         mack <= next_mack;
         v_hold <= next_v_hold;
         i_hold <= next_i_hold;
      end
   end

   // Open-drain data pin and status outputs
   assign sda_out = 1'b0;
   assign sda_oe_n_out = ~drive;
   assign alert_status_byte_out = status_byte; // R12
   assign busy_out = (state != MRS_IDLE);

   // Checks on the system clock, idle while in reset
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   // Address phase: only an own read address is acknowledged
   a_addr_ack_drive: assert property (state == MRS_ADDR && bus.scl_fall && cnt == 4'h8 && addr_hit // R2
      && !bus.start_det && !bus.stop_det |=> state == MRS_AACK && drive)
      else $error("own read address not acked");
   a_no_ack_write: assert property (state == MRS_ADDR && bus.scl_fall && cnt == 4'h8 && !shreg[0] // R2
      && !bus.start_det && !bus.stop_det |=> state == MRS_IDLE && !drive)
      else $error("write address wrongly acked");
   a_idle_quiet: assert property (state == MRS_IDLE |-> !drive) // R2
      else $error("data pulled low while idle");

   // Byte layout at the moment of loading
   a_single_count: assert property ($rose(state == MRS_AACK) && !status_read_in // R4
      && !(convert_voltage_in && convert_current_in) |-> left == 2'h2)
      else $error("single channel byte count wrong");
   a_status_one: assert property ($rose(state == MRS_AACK) && status_read_in |-> left == 2'h1 // R5 R13
      && obuf[23:16] == $past(status_byte))
      else $error("status read not one status byte");
   a_both_layout: assert property ($rose(state == MRS_AACK) && !status_read_in && convert_voltage_in // R15
      && convert_current_in |-> left == 2'h3 && obuf[23:16] == $past(v_hold[11:4])
      && obuf[15:8] == $past(i_hold[11:4]) && obuf[3:0] == $past(i_hold[3:0]))
      else $error("combined layout wrong");
   a_current_low: assert property ($rose(state == MRS_AACK) && !status_read_in && !convert_voltage_in // R1
      |-> obuf[23:16] == $past(i_hold[11:4]) && obuf[15:12] == $past(i_hold[3:0]) && obuf[11:8] == 4'h0)
      else $error("current low byte layout wrong");

   // Data phase: bits follow the buffer, bus freed for the answer
   a_send_bit: assert property (state == MRS_SEND |-> drive == !obuf[23]) // R1 R15
      else $error("data bit does not match buffer");
   a_mack_release: assert property (state == MRS_MACK |-> !drive) // R3
      else $error("data held during master answer");
   a_nack_release: assert property (state == MRS_MACK && !mack && bus.scl_fall && !bus.start_det // R3
      && !bus.stop_det |=> state == MRS_IDLE ##1 !drive)
      else $error("bus not released after nack");
   a_hold_stable: assert property (!result_valid_in |=> $stable(v_hold) && $stable(i_hold)) // R16
      else $error("result snapshot changed without conversion");

   // Main scenarios
   c_three_byte: cover property (state == MRS_MACK && left == 2'h0 && convert_voltage_in && convert_current_in);
   c_status_read: cover property ($rose(state == MRS_AACK) && status_read_in);
   c_current_read: cover property ($rose(state == MRS_AACK) && !status_read_in && !convert_voltage_in);
   c_refused: cover property (state == MRS_ADDR && bus.scl_fall && cnt == 4'h8 && !addr_hit);
   c_restart: cover property (state == MRS_SEND && bus.start_det);
endmodule : mrs_readback

// ==== mrs_master_model.sv ====
`timescale 1ns/10ps
// Bus master on the far side of the read port
module mrs_master_model (
   input wire logic clk_in,
   input wire logic sda_in, // Resolved data line
   output logic scl_out, // Bus clock, stands high outside frames
   output logic sda_oe_n_out, // Low while pulling data low
   output logic byte_valid_out, // One-cycle pulse per byte taken
   output logic [7:0] byte_out // Byte taken from the target
);
   // Idle bus: both lines released to the pull-ups
   initial begin
      scl_out = 1'b1;
      sda_oe_n_out = 1'b1;
      byte_valid_out = 1'b0;
      byte_out = 8'h00;
   end
   // Wait falling clock edges
   task automatic gap(input int n);
      repeat (n) @(negedge clk_in);
   endtask : gap
   // One bus clock; data set mid-low, sampled late in the high phase
   task automatic bit_xfer(input logic b, output logic seen);
      sda_oe_n_out = b;
      gap(4);
      scl_out = 1'b1;
      gap(8);
      seen = sda_in;
      scl_out = 1'b0;
      gap(4);
   endtask : bit_xfer
   // Whole read frame: start, address, bytes, answers, stop
   task automatic read_xfer(input logic [6:0] a, input logic rw, input int n, input logic ack_last,
                            output logic acked);
      logic s;
      logic [7:0] v;
      logic [7:0] ab;
      ab = {a, rw};
      // Start: data falls while clock high
      sda_oe_n_out = 1'b0;
      gap(8);
      scl_out = 1'b0;
      gap(4);
      // Address MSB first, then direction bit
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(ab[i], s);
      end
      // Released for the target's acknowledge
      bit_xfer(1'b1, s);
      acked = ~s;
      for (int k = 0; k < n && acked; k++) begin
         // Released while the target sends
         for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            v[i] = s;
         end
         byte_out = v;
         byte_valid_out = 1'b1;
         gap(1);
         byte_valid_out = 1'b0;
         // Ack all but the last byte, which gets the chosen answer
         bit_xfer((k == n - 1) ? ~ack_last : 1'b0, s);
      end
      // Stop: data rises while clock high
      sda_oe_n_out = 1'b0;
      gap(4);
      scl_out = 1'b1;
      gap(8);
      sda_oe_n_out = 1'b1;
      gap(8);
   endtask : read_xfer
endmodule : mrs_master_model

// ==== mrs_readback_test.sv ====
`timescale 1ns/10ps
module mrs_readback_test import mrs_pkg::*;;
   logic clk_in, rst_in, scl, sda, dsda, doen, moen, bval, clb, busy;
   logic st_rd, cv, cc, rv, eso, ero, efa, eoff, soc, fev, pin, fdis, clw;
   logic [7:0] bdat, th, stb;
   logic [11:0] vr, cr, v, c;
   logic [6:0] addr;
   logic [31:0] seed;
   logic [7:0] exp_q[$]; // Bytes expected from the target
   int failures, tests_run, n;
   // Open-drain data line with pull-up
   assign sda = (doen | dsda) & moen;
   mrs_readback dut (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl), .sda_in(sda), .sda_out(dsda),
      .sda_oe_n_out(doen), .device_address_in(addr), .status_read_in(st_rd), .convert_voltage_in(cv),
      .convert_current_in(cc), .result_valid_in(rv), .voltage_result_in(vr), .current_result_in(cr),
      .current_alert_threshold_in(th), .en_single_oc_in(eso), .en_run_oc_in(ero),
      .switch_failure_alert_enable_in(efa), .en_off_alert_in(eoff), .switch_off_overcurrent_flag_in(soc),
      .switch_fail_event_in(fev), .enable_pin_in(pin), .software_force_disable_bit_in(fdis),
      .clear_write_in(clw), .clear_bit_out(clb), .alert_status_byte_out(stb), .busy_out(busy));
   mrs_master_model m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_n_out(moen),
      .byte_valid_out(bval), .byte_out(bdat));
   // Clock, 8 ns period
   initial clk_in = 1'b0;
   always #4 clk_in = ~clk_in;
   // Pseudo-random source
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xorshift
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask : cyc
   // Live status byte after one more edge
   task automatic chk_st(input logic [7:0] e);
      cyc(1);
      check(stb, e);
   endtask : chk_st
   // One completed conversion set, then scramble the inputs
   task automatic convert(input logic [11:0] a, input logic [11:0] b);
      vr = a;
      cr = b;
      rv = 1'b1;
      cyc(1);
      rv = 1'b0;
      vr = ~a;
      cr = ~b;
      cyc(1);
   endtask : convert
   task automatic do_read(input logic [6:0] a, input logic rw, input int k, input logic al, input logic ea);
      logic ack;
      m.read_xfer(a, rw, k, al, ack);
      check({7'h00, ack}, {7'h00, ea});
      check({7'h00, busy}, 8'h00);
   endtask : do_read
   // Pulse the clear write and watch the self-clearing bit
   task automatic clear_seq(input logic [7:0] e);
      clw = 1'b1;
      cyc(1);
      clw = 1'b0;
      check({7'h00, clb}, 8'h01);
      cyc(1);
      check({7'h00, clb}, 8'h00);
      check(stb, e);
   endtask : clear_seq
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   // Each byte taken by the master is matched with the oldest note
   always @(posedge clk_in) begin
      if (bval === 1'b1) begin
         check(bdat, exp_q.size() ? exp_q.pop_front() : 8'hxx);
      end
   end
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_in);
      failures++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      give_verdict();
   end
   // Main sequence
   initial begin
      rst_in = 1'b1;
      {st_rd, cv, cc, rv, eso, ero, efa, eoff, soc, fev, fdis, clw} = 12'h000;
      pin = 1'b1;
      th = 8'hff;
      vr = 12'h000;
      cr = 12'h000;
      addr = 7'h2c;
      seed = 32'h10b8;
      failures = 0;
      tests_run = 0;
      repeat (3) @(posedge clk_in);
      cyc(1);
      rst_in = 1'b0;
      cyc(2);
      check(stb, 8'h00);
      check({6'h00, busy, doen}, 8'h01);
      $display("Test reset done");
      // Every conversion read mode; the combined read also sees a new set mid-transfer
      for (int md = 0; md < 4; md++) begin
         seed = xorshift(seed);
         v = seed[11:0];
         c = seed[27:16];
         cv = md[1];
         cc = md[0];
         convert(v, c);
         n = (md == 3) ? 3 : 2;
         if (md == 3) begin
            exp_q.push_back(v[11:4]);
            exp_q.push_back(c[11:4]);
            exp_q.push_back({v[3:0], c[3:0]});
         end else begin
            exp_q.push_back(md == 2 ? v[11:4] : c[11:4]);
            exp_q.push_back({md == 2 ? v[3:0] : c[3:0], 4'h0});
         end
         fork
            do_read(addr, 1'b1, n, 1'b0, 1'b1);
            if (md == 3) begin
               cyc(300);
               convert(~v, ~c);
            end
         join
      end
      $display("Test modes done");
      // Other address and write direction are refused
      do_read(addr ^ 7'h01, 1'b1, 2, 1'b0, 1'b0);
      do_read(addr, 1'b0, 2, 1'b0, 1'b0);
      $display("Test refusal done");
      // Run of conversions over a random threshold, then a boundary value
      th = {1'b0, seed[6:0]};
      c = {th + 8'h01, seed[11:8]};
      convert(v, c);
      convert(v, c);
      check(stb, 8'h00);
      convert(v, c);
      check(stb, 8'h01);
      convert(v, {th, 4'hf});
      check(stb, 8'h00);
      eso = 1'b1;
      convert(v, c);
      eso = 1'b0;
      convert(v, {th, 4'hf});
      check(stb, 8'h02);
      soc = 1'b1;
      chk_st(8'h06);
      soc = 1'b0;
      chk_st(8'h02);
      efa = 1'b1;
      fev = 1'b1;
      cyc(1);
      fev = 1'b0;
      cyc(4);
      check(stb, 8'h0a);
      eoff = 1'b1;
      pin = 1'b0;
      cyc(2);
      chk_st(8'h3a);
      pin = 1'b1;
      chk_st(8'h2a);
      fdis = 1'b1;
      chk_st(8'h3a);
      fdis = 1'b0;
      chk_st(8'h2a);
      $display("Test flags done");
      // Status read leaves the sticky bits alone
      st_rd = 1'b1;
      exp_q.push_back(8'h2a);
      do_read(addr, 1'b1, 1, 1'b1, 1'b1);
      st_rd = 1'b0;
      check(stb, 8'h2a);
      // Clear with a failure still present, then with none
      fev = 1'b1;
      clear_seq(8'h08);
      fev = 1'b0;
      clear_seq(8'h00);
      // Run enable trips only on the fourth over-threshold conversion
      ero = 1'b1;
      repeat (3) convert(v, c);
      check(stb, 8'h01);
      convert(v, c);
      check(stb, 8'h03);
      $display("Test clear done");
      check({7'h00, exp_q.size() == 0}, 8'h01);
      give_verdict();
   end
endmodule : mrs_readback_test
